// >>> hdl/ofd_operand_decoder.v
`timescale 1ns/1ps
`include "ofd_regs.vh"

module ofd_operand_decoder #(
  // Instruction word width and width of the program-address extension
  parameter INSN_W = 24,
  parameter EXT_W = 7
) (
  // Clock and asynchronous active-low reset
  input wire pclk,
  input wire presetn,
  // APB slave side
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Decode handshake and result words
  output reg dec_valid,
  output reg dec_exec,
  output reg dec_illegal,
  output reg [31:0] dec_res0,
  output reg [31:0] dec_res1,
  output reg [31:0] dec_res2,
  output reg [31:0] dec_res3,
  // Mirror of the status flag register
  output reg [11:0] status_flags
);

  // Software-visible source registers
  reg [INSN_W-1:0] insn_r; // Instruction word under decode
  reg [11:0] ctrl_r; // Class, size, base register, write-back
  reg [EXT_W-1:0] ext_r; // Upper bits of the program address literal
  reg start_r; // One-cycle pulse after an instruction write

  // APB decode terms
  // A transfer is taken once, on the edge before pready rises
  wire acc_phase; // Access phase, answer not yet given
  wire wr_ev; // Write takes effect this edge
  wire addr_ok; // Address hits a mapped register
  assign acc_phase = psel & penable & ~pready;
  assign wr_ev = acc_phase & pwrite;
  assign addr_ok = (paddr == `OFD_INSN_OFS) | (paddr == `OFD_CTRL_OFS) | (paddr == `OFD_EXT_OFS) |
                   (paddr == `OFD_RES0_OFS) | (paddr == `OFD_RES1_OFS) | (paddr == `OFD_RES2_OFS) |
                   (paddr == `OFD_RES3_OFS) | (paddr == `OFD_STAT_OFS) | (paddr == `OFD_FUPD_OFS);

  // Control fields
  // Fields are read live, so software writes the control word before the instruction
  wire [3:0] cl; // Operand class
  wire [1:0] sz; // Size suffix code
  wire [3:0] base_f; // Base register field
  wire [1:0] acc_writeback_dest_f; // Write-back destination code
  wire [7:0] opc; // Opcode byte
  wire [15:0] opf; // Operand bits
  assign cl = ctrl_r[`OFD_CTRL_CLASS_LSB+3:`OFD_CTRL_CLASS_LSB];
  assign sz = ctrl_r[`OFD_CTRL_SIZE_LSB+1:`OFD_CTRL_SIZE_LSB];
  assign base_f = ctrl_r[`OFD_CTRL_BASE_LSB+3:`OFD_CTRL_BASE_LSB];
  assign acc_writeback_dest_f = ctrl_r[`OFD_CTRL_WB_DEST_LSB+1:`OFD_CTRL_WB_DEST_LSB];
  assign opc = insn_r[`OFD_OPC_MSB:`OFD_OPC_LSB];
  assign opf = insn_r[15:0];

  // Mode legality: general operands stop at pre-increment, DSP ones allow offset
  // Mode code 7 is never legal; offset mode is refused unless the caller allows it
  // A refused mode makes the whole word illegal rather than falling back to direct
  function mode_ok;
    input [2:0] mode;
    input allow_ofs;
    begin
      mode_ok = (mode <= `OFD_AM_PREINC) | (allow_ofs & (mode == `OFD_AM_REGOFS));
    end
  endfunction

  // Prefetch code: 0..6 first pointer, 7..13 second, 14 indexed by the second pointer, 15 none
  // Result is {indexed, signed step[3:0], pointer[3:0], enable}
  // Both spaces share the table; only the first pointer register differs
  // Steps are kept as signed nibbles so the address unit can add them directly
  function [9:0] pf_dec;
    input [3:0] code;
    input [3:0] first;
    reg [3:0] kk;
    reg [2:0] k;
    reg [3:0] step;
    reg [3:0] ptr;
    begin
      // Fold the second pointer's codes onto the same step table
      kk = (code < 4'h7) ? code : code - 4'h7;
      k = kk[2:0];
      ptr = (code < 4'h7) ? first : first + 4'h1;
      case (k)
        3'h0: step = 4'h6;
        3'h1: step = 4'h4;
        3'h2: step = 4'h2;
        3'h4: step = 4'ha;
        3'h5: step = 4'hc;
        3'h6: step = 4'he;
        default: step = 4'h0;
      endcase
      if (code == 4'hf) begin
        pf_dec = 10'h000; // Prefetch omitted
      end else if (code == 4'he) begin
        pf_dec = {1'b1, 4'h0, first + 4'h1, 1'b1};
      end else begin
        pf_dec = {1'b0, step, ptr, 1'b1};
      end
    end
  endfunction

  // Distinct multiplier pairs; bit 8 marks an unused code
  // Only six of eight codes name a pair; the rest are refused as illegal
  // Listing the pairs keeps the factor order fixed for the multiplier
  function [8:0] pair_dec;
    input [2:0] code;
    begin
      case (code)
        3'h0: pair_dec = {1'b0, 4'h4, 4'h5};
        3'h1: pair_dec = {1'b0, 4'h4, 4'h6};
        3'h2: pair_dec = {1'b0, 4'h4, 4'h7};
        3'h3: pair_dec = {1'b0, 4'h5, 4'h6};
        3'h4: pair_dec = {1'b0, 4'h5, 4'h7};
        3'h5: pair_dec = {1'b0, 4'h6, 4'h7};
        default: pair_dec = {1'b1, 8'h00};
      endcase
    end
  endfunction

  // Combinational decode results
  // Every field has a default, so no class leaves a latch behind
  reg ill_nxt; // Word is illegal
  reg [3:0] src_nxt;
  reg [2:0] smode_nxt;
  reg [3:0] dst_nxt;
  reg [2:0] dmode_nxt;
  reg dst_w0_nxt;
  reg acc_nxt;
  reg [22:0] lit_nxt;
  reg [3:0] mula_nxt;
  reg [3:0] mulb_nxt;
  reg [3:0] xd_nxt;
  reg [3:0] yd_nxt;
  // Prefetch and write-back fields, used by the multiply classes
  reg [1:0] acc_writeback_dest_nxt;
  reg [9:0] xpf_nxt;
  reg [9:0] ypf_nxt;
  reg [8:0] pair_w;

  // Field extraction and legality per class
  // Defaults follow the general register layout; each class except register to register then overrides
  always @* begin
    ill_nxt = (sz > `OFD_SZ_DWORD);
    src_nxt = opf[3:0];
    smode_nxt = opf[6:4];
    dst_nxt = opf[10:7];
    dmode_nxt = opf[13:11];
    dst_w0_nxt = 1'b0;
    acc_nxt = 1'b0;
    lit_nxt = 23'h000000;
    mula_nxt = 4'h0;
    mulb_nxt = 4'h0;
    xd_nxt = `OFD_W4 + {2'b00, opf[13:12]};
    yd_nxt = `OFD_W4 + {2'b00, opf[15:14]};
    acc_writeback_dest_nxt = acc_writeback_dest_f;
    xpf_nxt = pf_dec(opf[7:4], `OFD_W8);
    ypf_nxt = pf_dec(opf[11:8], `OFD_W10);
    pair_w = pair_dec(opf[3:1]);
    case (cl)
      // File register: 13-bit address, top bit routes the result to W0
      `OFD_CL_FILE: begin
        lit_nxt = {8'h00, opf[14:0]};
        ill_nxt = ill_nxt | (opf[14:0] > `OFD_FILE_MAX);
        dst_w0_nxt = opf[15];
        dst_nxt = `OFD_W0;
        src_nxt = `OFD_W0;
      end
      // Register to register: general modes only
      `OFD_CL_WOPS: begin
        ill_nxt = ill_nxt | ~mode_ok(smode_nxt, 1'b0) | ~mode_ok(dmode_nxt, 1'b0);
      end
      // Accumulator operand: offset mode allowed, accumulator in bit 14
      `OFD_CL_DSPOP: begin
        acc_nxt = opf[14];
        ill_nxt = ill_nxt | ~mode_ok(smode_nxt, 1'b1) | ~mode_ok(dmode_nxt, 1'b1);
      end
      // Unsigned literal: byte operations take only the low 8-bit range
      `OFD_CL_ULIT: begin
        lit_nxt = {13'h0000, opf[9:0]};
        dst_nxt = opf[13:10];
        ill_nxt = ill_nxt | ((sz == `OFD_SZ_BYTE) & (opf[9:0] > `OFD_BYTE_LIT_MAX));
      end
      // Signed literal: sign bit copied up to the literal width
      `OFD_CL_SLIT: begin
        lit_nxt = {{13{opf[9]}}, opf[9:0]};
        dst_nxt = opf[13:10];
      end
      // Bit operation: every 4-bit position is legal, the mode is checked
      `OFD_CL_BIT: begin
        lit_nxt = {19'h00000, opf[3:0]};
        src_nxt = opf[7:4];
        smode_nxt = opf[10:8];
        ill_nxt = ill_nxt | ~mode_ok(opf[10:8], 1'b0);
      end
      // Multiply: pair table, write-back code checked
      `OFD_CL_MAC: begin
        acc_nxt = opf[0];
        mula_nxt = pair_w[7:4];
        mulb_nxt = pair_w[3:0];
        ill_nxt = ill_nxt | pair_w[8] | (acc_writeback_dest_f > `OFD_WB_DEST_POSTINC);
      end
      // Square: both factors the same register, spare bit must be clear
      `OFD_CL_SQR: begin
        acc_nxt = opf[0];
        mula_nxt = `OFD_W4 + {2'b00, opf[2:1]};
        mulb_nxt = `OFD_W4 + {2'b00, opf[2:1]};
        ill_nxt = ill_nxt | opf[3] | (acc_writeback_dest_f > `OFD_WB_DEST_POSTINC);
      end
      // Divide: both operands must be plain registers
      `OFD_CL_DIV: begin
        dst_nxt = opf[7:4];
        smode_nxt = opf[10:8];
        dmode_nxt = opf[13:11];
        ill_nxt = ill_nxt | (opf[10:8] != `OFD_AM_DIRECT) | (opf[13:11] != `OFD_AM_DIRECT);
      end
      // Program address: extension bits on top, must be even
      `OFD_CL_PADDR: begin
        lit_nxt = {ext_r, opf};
        ill_nxt = ill_nxt | opf[0];
      end
      // Codes 10 to 15 decode to nothing
      default: begin
        ill_nxt = 1'b1; // Unknown class
      end
    endcase
  end

  // Prefetch and write-back only mean something for multiply classes
  // Other classes report zero there so stale codes never reach the address units
  wire dsp_cl;
  assign dsp_cl = (cl == `OFD_CL_MAC) | (cl == `OFD_CL_SQR);

  // Result words assembled from the decode
  // Layouts are fixed so software can read any field without knowing the class
  wire [31:0] res0_w;
  wire [31:0] res1_w;
  wire [31:0] res2_w;
  wire [31:0] res3_w;
  assign res0_w = {8'h00, dst_w0_nxt, acc_nxt, base_f, dmode_nxt, dst_nxt, smode_nxt, src_nxt, sz, 2'b00};
  assign res1_w = {1'b0, lit_nxt, 8'h00};
  assign res2_w = dsp_cl ? {14'h0000, acc_writeback_dest_nxt, yd_nxt, xd_nxt, mulb_nxt, mula_nxt} :
                  {14'h0000, 2'b00, 16'h0000};
  assign res3_w = dsp_cl ? {6'h00, ypf_nxt, 6'h00, xpf_nxt} : 32'h00000000;

  // Sticky zero: a flag update may clear Z, never set it
  // Lets a chain of partial results keep one zero verdict for the whole value
  wire [11:0] fupd_w;
  assign fupd_w = {pwdata[`OFD_ST_ACC_B_SATURATE], pwdata[`OFD_ST_ACC_A_SATURATE],
                   pwdata[`OFD_ST_ACC_B_OVERFLOW], pwdata[`OFD_ST_ACC_A_OVERFLOW], 3'b000,
                   status_flags[`OFD_ST_Z] & pwdata[`OFD_ST_Z], pwdata[`OFD_ST_SIGNED_OVERFLOW],
                   pwdata[`OFD_ST_N], pwdata[`OFD_ST_HALF_CARRY], pwdata[`OFD_ST_C]};

  // Read mux
  // Write-only and unmapped places read as zero rather than echoing the bus
  reg [31:0] rd_nxt;
  always @* begin
    case (paddr)
      `OFD_INSN_OFS: rd_nxt = {8'h00, insn_r};
      `OFD_CTRL_OFS: rd_nxt = {20'h00000, ctrl_r};
      `OFD_EXT_OFS: rd_nxt = {25'h0000000, ext_r};
      `OFD_RES0_OFS: rd_nxt = dec_res0;
      `OFD_RES1_OFS: rd_nxt = dec_res1;
      `OFD_RES2_OFS: rd_nxt = dec_res2;
      `OFD_RES3_OFS: rd_nxt = dec_res3;
      `OFD_STAT_OFS: rd_nxt = {20'h00000, status_flags};
      default: rd_nxt = 32'h00000000; // Unmapped and write-only read as zero
    endcase
  end

  // APB slave: one wait state, answer registered
  // Registering the answer keeps prdata and pready straight from flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc_phase;
      pslverr <= acc_phase & ~addr_ok;
      prdata <= (acc_phase & ~pwrite) ? rd_nxt : 32'h00000000;
    end
  end

  // Software-written registers
  // The instruction write also launches the decode one cycle later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_r <= {INSN_W{1'b0}};
      ctrl_r <= `OFD_CTRL_RST;
      ext_r <= {EXT_W{1'b0}};
      start_r <= 1'b0;
    end else begin
      start_r <= wr_ev & (paddr == `OFD_INSN_OFS);
      if (wr_ev & (paddr == `OFD_INSN_OFS)) begin
        insn_r <= pwdata[INSN_W-1:0];
      end
      if (wr_ev & (paddr == `OFD_CTRL_OFS)) begin
        ctrl_r <= pwdata[11:0];
      end
      if (wr_ev & (paddr == `OFD_EXT_OFS)) begin
        ext_r <= pwdata[EXT_W-1:0];
      end
    end
  end

  // Status flags; the update port keeps zero sticky
  // A direct write loads every flag; unused bits stay zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags <= 12'h000;
    end else if (wr_ev & (paddr == `OFD_STAT_OFS)) begin
      status_flags <= {pwdata[11:8], 3'b000, pwdata[4:0]};
    end else if (wr_ev & (paddr == `OFD_FUPD_OFS)) begin
      status_flags <= fupd_w;
    end
  end

  // Latch results one cycle after the instruction write
  // dec_valid and dec_exec pulse for one cycle; the verdict and words hold
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid <= 1'b0;
      dec_exec <= 1'b0;
      dec_illegal <= 1'b0;
      dec_res0 <= 32'h00000000;
      dec_res1 <= 32'h00000000;
      dec_res2 <= 32'h00000000;
      dec_res3 <= 32'h00000000;
    end else begin
      dec_valid <= start_r;
      dec_exec <= start_r & ~ill_nxt;
      if (start_r) begin
        dec_illegal <= ill_nxt;
        // Illegal words keep only the opcode and flag, so nothing downstream acts on stale fields
        dec_res0 <= ill_nxt ? 32'h00000001 : res0_w;
        dec_res1 <= ill_nxt ? {24'h000000, opc} : (res1_w | {24'h000000, opc});
        dec_res2 <= ill_nxt ? 32'h00000000 : res2_w;
        dec_res3 <= ill_nxt ? 32'h00000000 : res3_w;
      end
    end
  end

endmodule

// >>> hdl/ofd_regs.vh
`ifndef OFD_REGS_VH
`define OFD_REGS_VH

// Register byte offsets (APB, one aligned word each)
`define OFD_INSN_OFS 8'h00
`define OFD_CTRL_OFS 8'h04
`define OFD_EXT_OFS 8'h08
`define OFD_RES0_OFS 8'h0c
`define OFD_RES1_OFS 8'h10
`define OFD_RES2_OFS 8'h14
`define OFD_RES3_OFS 8'h18
`define OFD_STAT_OFS 8'h1c
`define OFD_FUPD_OFS 8'h20

// Instruction word layout
`define OFD_INSN_W 24
`define OFD_OPC_MSB 23
`define OFD_OPC_LSB 16

// Control register fields
`define OFD_CTRL_CLASS_LSB 0
`define OFD_CTRL_SIZE_LSB 4
`define OFD_CTRL_BASE_LSB 6
`define OFD_CTRL_WB_DEST_LSB 10
`define OFD_CTRL_RST 12'h000

// Operand classes
`define OFD_CL_FILE 4'h0
`define OFD_CL_WOPS 4'h1
`define OFD_CL_ULIT 4'h2
`define OFD_CL_SLIT 4'h3
`define OFD_CL_BIT 4'h4
`define OFD_CL_MAC 4'h5
`define OFD_CL_SQR 4'h6
`define OFD_CL_DIV 4'h7
`define OFD_CL_PADDR 4'h8
`define OFD_CL_DSPOP 4'h9

// Operation sizes; word is the default encoding
`define OFD_SZ_WORD 2'h0
`define OFD_SZ_BYTE 2'h1
`define OFD_SZ_DWORD 2'h2

// Addressing modes of a register operand
`define OFD_AM_DIRECT 3'h0
`define OFD_AM_IND 3'h1
`define OFD_AM_POSTDEC 3'h2
`define OFD_AM_POSTINC 3'h3
`define OFD_AM_PREDEC 3'h4
`define OFD_AM_PREINC 3'h5
`define OFD_AM_REGOFS 3'h6

// Write-back destination codes
`define OFD_WB_DEST_NONE 2'h0
`define OFD_WB_DEST_DIRECT 2'h1
`define OFD_WB_DEST_POSTINC 2'h2

// Fixed registers and limits
`define OFD_FILE_MAX 15'h1fff
`define OFD_BYTE_LIT_MAX 10'h0ff
`define OFD_W0 4'h0
`define OFD_W4 4'h4
`define OFD_W8 4'h8
`define OFD_W10 4'ha
`define OFD_W12 4'hc
`define OFD_W13 4'hd

// Status register bit positions
`define OFD_ST_C 0
`define OFD_ST_HALF_CARRY 1
`define OFD_ST_N 2
`define OFD_ST_SIGNED_OVERFLOW 3
`define OFD_ST_Z 4
`define OFD_ST_ACC_A_OVERFLOW 8
`define OFD_ST_ACC_B_OVERFLOW 9
`define OFD_ST_ACC_A_SATURATE 10
`define OFD_ST_ACC_B_SATURATE 11

`endif

// >>> verif/ofd_monitor.sv
`timescale 1ns/1ps
// Port-level checks of the APB slave and the decode handshake
module ofd_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dec_valid,
  input wire logic dec_exec,
  input wire logic dec_illegal,
  input wire logic [31:0] dec_res0,
  input wire logic [31:0] dec_res1,
  input wire logic [31:0] dec_res2,
  input wire logic [31:0] dec_res3,
  input wire logic [11:0] status_flags
);
  default clocking mc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase ends one cycle after it is taken
  pready_follow_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  // Decode fires a fixed two samples after the instruction write is taken
  dec_latency_a: assert property (psel && penable && pwrite && !pready && paddr == 8'h00 |-> ##2 dec_valid) else $error("decode late");
  dec_pulse_a: assert property (dec_valid |=> !dec_valid) else $error("dec_valid too long");
  verdict_hold_a: assert property (!dec_valid |-> $stable(dec_illegal)) else $error("verdict moved");
  exec_verdict_a: assert property (dec_valid |-> dec_exec == !dec_illegal) else $error("exec mismatch");
  illegal_clear_a: assert property (dec_valid && dec_illegal |-> dec_res0 == 32'h1 && dec_res2 == 32'h0) else $error("fields kept");
endmodule
bind ofd_operand_decoder ofd_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dec_valid(dec_valid), .dec_exec(dec_exec), .dec_illegal(dec_illegal), .dec_res0(dec_res0),
  .dec_res1(dec_res1), .dec_res2(dec_res2), .dec_res3(dec_res3), .status_flags(status_flags));

// >>> verif/tb_operand_field_decoder.sv
`timescale 1ns/1ps
module tb_operand_field_decoder;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, seed = 32'h40637977;
  logic pready, pslverr, dec_valid, dec_exec, dec_illegal;
  logic [31:0] dec_res0, dec_res1, dec_res2, dec_res3;
  logic [11:0] status_flags;
  int failures = 0, n_compared = 0, cyc = 0, i;
  wire [31:0] prdata_w; // Read data of the slave
  logic [7:0] pairs [6] = '{8'h54, 8'h64, 8'h74, 8'h65, 8'h75, 8'h76}; // Multiply pairs {b, a}
  ofd_operand_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_w), .pready(pready), .pslverr(pslverr), .dec_valid(dec_valid),
    .dec_exec(dec_exec), .dec_illegal(dec_illegal), .dec_res0(dec_res0), .dec_res1(dec_res1),
    .dec_res2(dec_res2), .dec_res3(dec_res3), .status_flags(status_flags));
  initial forever #4 pclk = ~pclk;
  // Hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  task test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata_w;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction
  // Reference verdict per operand class
  function logic ill(input logic [3:0] cl, input logic [1:0] sz, input logic [1:0] aw, input logic [23:0] w);
    case (cl)
      0: ill = w[14:0] > 15'h1fff;
      1: ill = w[6:4] > 5 || w[13:11] > 5;
      9: ill = w[6:4] > 6 || w[13:11] > 6;
      2: ill = sz == 1 && w[9:0] > 255;
      3: ill = 0;
      4: ill = w[10:8] > 5;
      5: ill = w[3:1] > 5;
      6: ill = w[3];
      7: ill = w[10:8] != 0 || w[13:11] != 0;
      8: ill = w[0];
      default: ill = 1;
    endcase
    ill = ill || sz == 3 || (aw == 3 && (cl == 5 || cl == 6));
  endfunction
  // Control first, then the instruction word, then await the decode pulse
  task dec(input logic [3:0] cl, input logic [1:0] sz, input logic [1:0] aw, input logic [23:0] w);
    logic e;
    apb(1, 8'h04, {20'h0, aw, 4'h0, sz, cl});
    apb(1, 8'h00, {8'h0, w});
    repeat (8) begin
      @(posedge pclk);
      if (dec_valid === 1'b1) break;
    end
    e = ill(cl, sz, aw, w);
    chk(dec_valid, 1);
    chk(dec_illegal, e);
    chk(dec_exec, !e);
    chk(dec_res1[7:0], w[23:16]);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    // Reset values, unmapped place, read-only result
    apb(0, 8'h04, 0); chk(rd, 0);
    apb(0, 8'h24, 0); chk({er, rd[30:0]}, 32'h80000000);
    apb(1, 8'h0c, 32'hffff); apb(0, 8'h0c, 0); chk(rd, 0);
    $display("registers done");
    dec(0, 0, 0, 24'h119fff); chk(dec_res0[23], 1);
    dec(0, 0, 0, 24'h112000);
    dec(2, 1, 0, 24'h1200ff); dec(2, 1, 0, 24'h120100); dec(2, 0, 0, 24'h1203ff);
    dec(3, 0, 0, 24'h130200); chk(dec_res1[30:8], 23'h7ffe00);
    dec(8, 0, 0, 24'h140003); dec(8, 0, 0, 24'h140002); chk(dec_res1[30:8], 2);
    apb(1, 8'h08, 32'h55); dec(8, 0, 0, 24'h140004); chk(dec_res1[30:8], 23'h550004);
    for (i = 0; i < 8; i++) begin
      dec(5, 0, 1, {8'h15, 12'h0, i[2:0], 1'b1}); if (i < 6) chk(dec_res0[22], 1);
      if (i < 6) chk(dec_res2[7:0], pairs[i]);
      dec(6, 0, 2, {8'h16, 12'h0, i[2:0], 1'b0}); if (i < 4) chk(dec_res2[7:0], {2{2'b01, i[1:0]}});
    end
    dec(5, 0, 2, 24'h157fe0); chk(dec_res3, 32'h213); chk(dec_res2[17:8], 10'h257);
    dec(5, 0, 1, 24'h150940); chk(dec_res3, 32'h00570151); chk(dec_res2[17:16], 1);
    dec(5, 0, 3, 24'h150000); dec(1, 3, 0, 24'h180000);
    dec(1, 2, 0, 24'h180000); chk(dec_res0[3:2], 2);
    dec(1, 0, 0, 24'h182d3f); chk(dec_res0, 32'h0002d3f0);
    dec(4, 0, 0, 24'h14000f); chk(dec_res1[30:8], 15);
    dec(7, 0, 0, 24'h170021); dec(7, 0, 0, 24'h170121);
    dec(1, 0, 0, 24'h180065); dec(9, 0, 0, 24'h190065); chk(dec_res0[10:8], 6);
    for (i = 10; i < 16; i++) dec(i[3:0], 0, 0, 24'h1a0000);
    $display("decode done");
    // Flags: full load, then zero flag may only clear
    apb(1, 8'h1c, 32'hffffffff); apb(0, 8'h1c, 0); chk(rd, 32'hf1f);
    apb(1, 8'h20, 32'h00f); apb(1, 8'h20, 32'h01f); apb(0, 8'h1c, 0); chk(rd, 32'h00f);
    chk(status_flags, 12'h00f);
    $display("flags done");
    for (i = 0; i < 40; i++) begin
      seed = xs(seed);
      dec(seed[31] ? 4'h9 : {1'b0, seed[30:28]}, seed[27:26] % 3, 0, seed[23:0]);
    end
    $display("random done");
    test_done;
  end
endmodule
